//--- inc/strobe_map.svh
// register map, opcodes and timing constants of the strobe coprocessor
`ifndef STROBE_MAP_SVH
`define STROBE_MAP_SVH
`define STROBE_PORT_ADDR  8'he1
`define STROBE_PORT_RESET 8'hc0
`define NOP_OPCODE        8'hc0
`define IMEM_DEPTH        24
`define CORE_CLK_MHZ      8
`define IMM_TOP_BITS      3'b111
`define STROBE_TOP_BITS   2'b11
`define PRG_LABEL         8'hba
`define RPT_TOP_BITS      4'ha
`define IMM_START         8'he1
`define IMM_STOP          8'he2
`define PRG_STOP          8'hdf
`define PRG_INT           8'hb9
`define PRG_WAITX         8'hbb
`define PRG_INCY          8'hbd
`define WAIT_TOP_BITS     3'b100
`define WAIT_ZERO_COUNT   6'h20
`define COUNTDOWN_HOLD    8'hff
`endif

//--- inc/strobe_pkg.sv
// types shared by the strobe coprocessor files
package strobe_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cpu_req_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] code;
  } strobe_s;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RUN  = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_IMM  = 4'b1000
  } seq_state_e;
endpackage

//--- verilog/instr_mem.sv
// 24-byte instruction memory with sequential write pointer
`timescale 1ns/100ps
`include "strobe_map.svh"
module instr_mem #(
  parameter int DEPTH = `IMEM_DEPTH
) (
  // clocking
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // write side
  input  wire logic       wr,
  input  wire logic [7:0] wdata,
  input  wire logic       ptr_clear,
  // read side
  input  wire logic [4:0] raddr,
  output logic      [7:0] rdata
);
  logic [7:0] mem_r [DEPTH];
  logic [7:0] mem_nxt [DEPTH];
  logic [4:0] wptr_r, wptr_nxt;

  // pointer sticks at the last slot so extra bytes overwrite it
  always_comb begin
    mem_nxt  = mem_r;
    wptr_nxt = wptr_r;
    if (wr) begin
      mem_nxt[wptr_r] = wdata;
      if (wptr_r != 5'(DEPTH - 1))
        wptr_nxt = wptr_r + 5'h01;
    end
    if (ptr_clear)
      wptr_nxt = 5'h00;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++)
        mem_r[i] <= `NOP_OPCODE;
      wptr_r <= 5'h00;
    end else if (ce) begin
      mem_r  <= mem_nxt;
      wptr_r <= wptr_nxt;
    end
  end

  assign rdata = (raddr < 5'(DEPTH)) ? mem_r[raddr] : `NOP_OPCODE;
endmodule

//--- verilog/countdown.sv
// overflow countdown register, decremented on each timer overflow while the sequencer runs, down to zero; a value of 0xff is held
`timescale 1ns/100ps
`include "strobe_map.svh"
module countdown (
  // clocking
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // control
  input  wire logic       load,
  input  wire logic [7:0] load_val,
  input  wire logic       running,
  input  wire logic       ovf,
  // state
  output logic      [7:0] value,
  output logic            zero
);
  logic [7:0] cnt_r, cnt_nxt;

  // 0xff means compare unused: never counts
  always_comb begin
    cnt_nxt = cnt_r;
    if (load)
      cnt_nxt = load_val;
    else if (running && ovf && cnt_r != `COUNTDOWN_HOLD && cnt_r != 8'h00)
      cnt_nxt = cnt_r - 8'h01;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      cnt_r <= `COUNTDOWN_HOLD;
    else if (ce)
      cnt_r <= cnt_nxt;
  end

  assign value = cnt_r;
  assign zero  = (cnt_r == 8'h00);
endmodule

//--- verilog/strobe_coprocessor.sv
// strobe coprocessor front end: instruction port, sequencer, strobe out
//
// Functional notes
// - one instruction port plus data and control registers
// - raises interrupt requests toward the cpu
// - timer overflows pace waits and countdown
// - immediate strobes and stored program modes
// - immediate strobes go straight to radio; one written in the ST_IMM slot after a preemption is dropped
// - immediate strobes start and stop programs
// - program fetched sequentially, nine instructions decoded
// - timer-paced program runs backoff without cpu
// - port writes stored in memory; resets 0xc0
// - port read returns executing instruction
// - memory holds 24 bytes, filled sequentially
// - memory resets to no-operation opcode
// - coprocessor logic clocked at 8 mhz
// - immediate strobe first, program instruction afterwards
`timescale 1ns/100ps
`include "strobe_map.svh"
module strobe_coprocessor #(
  parameter int DEPTH = `IMEM_DEPTH
) (
  // clocking, core runs at 8 mhz
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                ce,
  // cpu special-function access
  input  wire strobe_pkg::cpu_req_s cpu_req,
  output logic               [7:0] cpu_rdata,
  // radio-space data and control registers
  input  wire logic                x_wr,
  input  wire logic                y_wr,
  input  wire logic                z_wr,
  input  wire logic                t_wr,
  input  wire logic                ctrl_wr,
  input  wire logic          [7:0] reg_wdata,
  output logic               [7:0] loop_data_reg_x,
  output logic               [7:0] general_data_reg_y,
  output logic               [7:0] general_data_reg_z,
  output logic               [7:0] overflow_countdown_reg,
  output logic               [7:0] coprocessor_control_reg,
  // mac timer
  input  wire logic                mac_ovf,
  // radio strobe
  output strobe_pkg::strobe_s      strobe,
  // interrupt flags and run status toward cpu
  output logic                     irq_stop,
  output logic                     irq_wait,
  output logic                     irq_int,
  output logic                     running
);
  strobe_pkg::seq_state_e st_r, st_nxt;
  logic [4:0] pc_r, pc_nxt, loop_r, loop_nxt;
  logic [5:0] wcnt_r, wcnt_nxt;
  logic [7:0] cur_r, cur_nxt, rd_r, rd_nxt;
  logic [7:0] x_r, x_nxt, y_r, y_nxt, z_r, z_nxt, ctl_r, ctl_nxt;
  strobe_pkg::strobe_s stb_r, stb_nxt;
  logic stop_r, stop_nxt, wt_r, wt_nxt, int_r, int_nxt, running_r, running_nxt;
  logic [7:0] imm_r, imm_nxt;
  logic [7:0] idata, t_val;
  logic       t_zero, port_wr, is_imm, mem_wr, ptr_clr, t_run;

  // top three bits set marks an immediate; 0xc0-0xdf must stay storable as program strobes
  function automatic logic imm_code(input logic [7:0] b);
    return b[7:5] == `IMM_TOP_BITS;
  endfunction

  // condition test shared by skip and repeat
  function automatic logic cond_true(input logic [2:0] c, input logic n,
                                     input logic [7:0] xv);
    logic r;
    r = (c == 3'h0) ? (xv == 8'h00) : (c == 3'h1) ? (xv != 8'h00) : 1'b0;
    return r ^ n;
  endfunction

  assign port_wr = cpu_req.wr && cpu_req.addr == `STROBE_PORT_ADDR;
  assign is_imm  = imm_code(cpu_req.wdata);
  // loading is only legal while idle; writes outside idle are not stored
  assign mem_wr  = port_wr && !is_imm && st_r == strobe_pkg::ST_IDLE;
  assign ptr_clr = port_wr && cpu_req.wdata == `IMM_STOP;
  assign t_run   = st_r != strobe_pkg::ST_IDLE;

  instr_mem #(.DEPTH(DEPTH)) u_mem (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .wr        (mem_wr),
    .wdata     (cpu_req.wdata),
    .ptr_clear (ptr_clr),
    .raddr     (pc_r),
    .rdata     (idata)
  );

  countdown u_cnt (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .load     (t_wr),
    .load_val (reg_wdata),
    .running  (t_run),
    .ovf      (mac_ovf),
    .value    (t_val),
    .zero     (t_zero)
  );

  // sequencer next state
  always_comb begin
    st_nxt   = st_r;
    pc_nxt   = pc_r;
    loop_nxt = loop_r;
    wcnt_nxt = wcnt_r;
    cur_nxt  = cur_r;
    imm_nxt  = imm_r;
    x_nxt    = x_wr ? reg_wdata : x_r;
    y_nxt    = y_wr ? reg_wdata : y_r;
    z_nxt    = z_wr ? reg_wdata : z_r;
    ctl_nxt  = ctrl_wr ? reg_wdata : ctl_r;
    stb_nxt  = '0;
    stop_nxt = 1'b0;
    wt_nxt   = 1'b0;
    int_nxt  = 1'b0;
    // immediate strobe preempts whatever runs
    if (port_wr && is_imm) begin
      if (cpu_req.wdata == `IMM_START && st_r == strobe_pkg::ST_IDLE) begin
        st_nxt = strobe_pkg::ST_RUN;
        pc_nxt = 5'h00;
      end else if (cpu_req.wdata == `IMM_STOP) begin
        st_nxt   = strobe_pkg::ST_IDLE;
        stop_nxt = t_run;
      end else if (st_r != strobe_pkg::ST_IMM && st_r != strobe_pkg::ST_IDLE) begin
        imm_nxt = cpu_req.wdata;
        stb_nxt = '{valid: 1'b1, code: cpu_req.wdata};
      end else if (st_r == strobe_pkg::ST_IDLE) begin
        stb_nxt = '{valid: 1'b1, code: cpu_req.wdata};
      end
    end else begin
      case (st_r)
        strobe_pkg::ST_IDLE: begin
          cur_nxt = `NOP_OPCODE;
        end
        strobe_pkg::ST_RUN: begin
          cur_nxt = idata;
          if (t_zero || pc_r >= 5'(DEPTH)) begin
            st_nxt   = strobe_pkg::ST_IDLE;
            stop_nxt = 1'b1;
          end else begin
            pc_nxt = pc_r + 5'h01;
            if (idata[7] == 1'b0) begin
              if (cond_true(idata[2:0], idata[3], x_r))
                pc_nxt = pc_r + 5'h01 + {2'h0, idata[6:4]};
            end else if (idata[7:5] == `WAIT_TOP_BITS) begin
              wcnt_nxt = (idata[4:0] == 5'h00) ? `WAIT_ZERO_COUNT : {1'b0, idata[4:0]};
              st_nxt   = strobe_pkg::ST_WAIT;
            end else if (idata == `PRG_WAITX) begin
              wcnt_nxt = x_r[5:0];
              st_nxt   = (x_r == 8'h00) ? strobe_pkg::ST_RUN : strobe_pkg::ST_WAIT;
            end else if (idata == `PRG_INT) begin
              int_nxt = 1'b1;
            end else if (idata == `PRG_INCY) begin
              y_nxt = y_r + 8'h01;
            end else if (idata == `PRG_LABEL) begin
              loop_nxt = pc_r + 5'h01;
            end else if (idata[7:4] == `RPT_TOP_BITS) begin
              if (cond_true(idata[2:0], idata[3], x_r))
                pc_nxt = loop_r;
            end else if (idata == `PRG_STOP) begin
              st_nxt   = strobe_pkg::ST_IDLE;
              stop_nxt = 1'b1;
            end else if (idata[7:6] == `STROBE_TOP_BITS && idata != `NOP_OPCODE) begin
              stb_nxt = '{valid: 1'b1, code: idata};
            end
          end
        end
        strobe_pkg::ST_WAIT: begin
          if (t_zero) begin
            st_nxt   = strobe_pkg::ST_IDLE;
            stop_nxt = 1'b1;
          end else if (mac_ovf) begin
            wcnt_nxt = wcnt_r - 6'h01;
            if (wcnt_r == 6'h01) begin
              st_nxt = strobe_pkg::ST_RUN;
              wt_nxt = 1'b1;
            end
          end
        end
        strobe_pkg::ST_IMM: begin
          st_nxt = strobe_pkg::ST_RUN;
        end
        default: st_nxt = strobe_pkg::ST_IDLE;
      endcase
    end
    // during a preemption the read shows the no-op code
    if (stb_nxt.valid && st_r != strobe_pkg::ST_IDLE && port_wr) begin
      st_nxt  = (st_r == strobe_pkg::ST_WAIT) ? strobe_pkg::ST_WAIT : strobe_pkg::ST_IMM;
      cur_nxt = `NOP_OPCODE;
    end
    rd_nxt = (cpu_req.rd && cpu_req.addr == `STROBE_PORT_ADDR) ? cur_nxt : rd_r;
    running_nxt = st_nxt != strobe_pkg::ST_IDLE;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r   <= strobe_pkg::ST_IDLE;
      pc_r   <= 5'h00;
      loop_r <= 5'h00;
      wcnt_r <= 6'h00;
      cur_r  <= `STROBE_PORT_RESET;
      rd_r   <= `STROBE_PORT_RESET;
      imm_r  <= `NOP_OPCODE;
      x_r    <= 8'h00;
      y_r    <= 8'h00;
      z_r    <= 8'h00;
      ctl_r  <= 8'h00;
      stb_r  <= '0;
      stop_r <= 1'b0;
      wt_r   <= 1'b0;
      int_r  <= 1'b0;
      running_r <= 1'b0;
    end else if (ce) begin
      st_r   <= st_nxt;
      pc_r   <= pc_nxt;
      loop_r <= loop_nxt;
      wcnt_r <= wcnt_nxt;
      cur_r  <= cur_nxt;
      rd_r   <= rd_nxt;
      imm_r  <= imm_nxt;
      x_r    <= x_nxt;
      y_r    <= y_nxt;
      z_r    <= z_nxt;
      ctl_r  <= ctl_nxt;
      stb_r  <= stb_nxt;
      stop_r <= stop_nxt;
      wt_r   <= wt_nxt;
      int_r  <= int_nxt;
      running_r <= running_nxt;
    end
  end

  // outputs straight from flops; countdown flop lives in its submodule
  assign cpu_rdata               = rd_r;
  assign loop_data_reg_x         = x_r;
  assign general_data_reg_y      = y_r;
  assign general_data_reg_z      = z_r;
  assign overflow_countdown_reg  = t_val;
  assign coprocessor_control_reg = ctl_r;
  assign strobe                  = stb_r;
  assign irq_stop                = stop_r;
  assign irq_wait                = wt_r;
  assign irq_int                 = int_r;
  assign running                 = running_r;

  // a strobe pulse lasts one cycle
  property p_strobe_single;
    @(posedge clk) disable iff (rst) ce && strobe.valid && !port_wr && st_r != strobe_pkg::ST_RUN |=> !strobe.valid;
  endproperty
  chk_strobe_pulse_single: assert property (p_strobe_single) else $error("strobe held two cycles");

  // an immediate write reaches the radio next cycle when idle
  chk_imm_strobe_out: assert property (@(posedge clk) disable iff (rst)
    ce && port_wr && is_imm && !running && cpu_req.wdata != `IMM_START && cpu_req.wdata != `IMM_STOP
    |=> strobe.valid && strobe.code == $past(cpu_req.wdata)) else $error("immediate strobe not issued");

  // start opcode launches the sequencer
  chk_start_runs: assert property (@(posedge clk) disable iff (rst)
    ce && port_wr && cpu_req.wdata == `IMM_START && !running |=> running) else $error("start ignored");

  // stop opcode halts and flags
  sequence s_stop_cmd;
    ce && port_wr && cpu_req.wdata == `IMM_STOP && running;
  endsequence
  chk_stop_halts: assert property (@(posedge clk) disable iff (rst)
    s_stop_cmd |=> !running && irq_stop) else $error("stop ignored");

  // preempted program resumes after the immediate slot
  chk_imm_resume: assert property (@(posedge clk) disable iff (rst)
    ce && st_r == strobe_pkg::ST_RUN && port_wr && is_imm && cpu_req.wdata != `IMM_STOP
    ##1 ce |=> st_r == strobe_pkg::ST_RUN) else $error("program not resumed");

  // read during preemption shows the no-op code
  chk_imm_read_nop: assert property (@(posedge clk) disable iff (rst)
    ce && st_r == strobe_pkg::ST_RUN && port_wr && is_imm && cpu_req.wdata != `IMM_STOP
    |=> cur_r == `NOP_OPCODE) else $error("read not no-op");

  // program counter advances one per executed no-op
  chk_pc_step: assert property (@(posedge clk) disable iff (rst)
    ce && st_r == strobe_pkg::ST_RUN && !port_wr && !t_zero && idata == `NOP_OPCODE && pc_r < 5'(DEPTH)
    |=> pc_r == $past(pc_r) + 5'h01) else $error("pc did not step");

  // a zero countdown ends the program
  chk_zero_stops: assert property (@(posedge clk) disable iff (rst)
    ce && running && t_zero && !port_wr && st_r != strobe_pkg::ST_IMM |=> !running) else $error("zero countdown");

  // program bytes are not stored while running
  chk_no_load_run: assert property (@(posedge clk) disable iff (rst)
    running |-> !mem_wr) else $error("load while running");
endmodule

//--- tb/radio_timer_model.sv
// far-side model: mac timer overflow source and radio strobe sink
`timescale 1ns/100ps
module radio_timer_model #(
  parameter int OVF_GAP = 10
) (
  // clocking
  input  wire logic                clk,
  input  wire logic                rst,
  // strobes from the coprocessor
  input  wire strobe_pkg::strobe_s strobe,
  // timer overflow and strobe log
  output logic                     mac_ovf,
  output logic               [7:0] last_code,
  output int                       strobe_cnt
);
  int gap_cnt;

  // one-cycle overflow pulse every OVF_GAP cycles, moved off the sampling edge
  always @(negedge clk or posedge rst) begin
    if (rst) begin
      gap_cnt <= 0;
      mac_ovf <= 1'h0;
    end else begin
      gap_cnt <= (gap_cnt == OVF_GAP - 1) ? 0 : gap_cnt + 1;
      mac_ovf <= (gap_cnt == OVF_GAP - 1);
    end
  end

  // radio side takes one command per sampled pulse, so a stuck valid counts twice
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      strobe_cnt <= 0;
      last_code  <= 8'hc0;
    end else if (strobe.valid === 1'h1) begin
      strobe_cnt <= strobe_cnt + 1;
      last_code  <= strobe.code;
    end
  end
endmodule

//--- tb/radio_strobe_coprocessor_front_test.sv
// self-checking bench for the strobe coprocessor front end
`timescale 1ns/100ps
`include "strobe_map.svh"
module radio_strobe_coprocessor_front_test;
  logic                 clk;
  logic                 rst;
  strobe_pkg::cpu_req_s cpu_req;
  strobe_pkg::strobe_s  strobe;
  strobe_pkg::strobe_s  s1;
  strobe_pkg::strobe_s  s2;
  logic           [7:0] cpu_rdata;
  logic           [4:0] reg_wr_v;
  logic           [7:0] reg_wdata;
  logic           [7:0] reg_x;
  logic           [7:0] reg_y;
  logic           [7:0] reg_z;
  logic           [7:0] reg_t;
  logic           [7:0] reg_ctrl;
  logic      [4:0][7:0] regs_out;
  logic           [2:0] irq_v;
  logic                 irq_stop;
  logic                 irq_wait;
  logic                 irq_int;
  logic                 running;
  logic                 mac_ovf;
  logic           [7:0] code;
  logic           [7:0] last_code;
  int                   irq_cnt[3];
  int                   strobe_cnt;
  int                   fails = 0;
  int                   checks_done = 0;
  int                   cycles = 0;
  int                   seed;

  assign regs_out = {reg_x, reg_y, reg_z, reg_t, reg_ctrl};
  assign irq_v    = {irq_stop, irq_wait, irq_int};

  strobe_coprocessor strobe_coprocessor_inst (
    .clk(clk), .rst(rst), .ce(1'h1), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata),
    .x_wr(reg_wr_v[4]), .y_wr(reg_wr_v[3]), .z_wr(reg_wr_v[2]), .t_wr(reg_wr_v[1]), .ctrl_wr(reg_wr_v[0]),
    .reg_wdata(reg_wdata), .loop_data_reg_x(reg_x), .general_data_reg_y(reg_y), .general_data_reg_z(reg_z),
    .overflow_countdown_reg(reg_t), .coprocessor_control_reg(reg_ctrl), .mac_ovf(mac_ovf), .strobe(strobe),
    .irq_stop(irq_stop), .irq_wait(irq_wait), .irq_int(irq_int), .running(running));

  radio_timer_model radio_timer_model_inst (
    .clk(clk), .rst(rst), .strobe(strobe), .mac_ovf(mac_ovf), .last_code(last_code), .strobe_cnt(strobe_cnt));

  // 25 mhz bench clock
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  // tally interrupt pulses, so a pulse is not missed while a task is busy
  always @(posedge clk) begin
    for (int k = 0; k < 3; k++) if (irq_v[k] === 1'h1) irq_cnt[k]++;
  end

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      test_done();
    end
  end

  task automatic test_done();
    if (fails == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one port write; the strobe is captured one and two cycles later
  task automatic port_wr(input logic [7:0] v);
    cpu_req.wr = 1'h1;
    cpu_req.addr = `STROBE_PORT_ADDR;
    cpu_req.wdata = v;
    @(negedge clk);
    cpu_req.wr = 1'h0;
    s1 = strobe;
    @(negedge clk);
    s2 = strobe;
  endtask

  task automatic cpu_rd();
    cpu_req.rd = 1'h1;
    cpu_req.addr = `STROBE_PORT_ADDR;
    @(negedge clk);
    cpu_req.rd = 1'h0;
    @(negedge clk);
  endtask

  task automatic reg_wr(input int idx, input logic [7:0] v);
    reg_wdata = v;
    reg_wr_v = 5'(5'h01 << idx);
    @(negedge clk);
    reg_wr_v = 5'h00;
    // let an edge pass so the next call does not re-raise the write enable in the same step
    @(negedge clk);
  endtask

  // bounded wait for an interrupt pulse, then exactly one must have come
  task automatic wait_irq(input int b, input int lim);
    for (int k = 0; k < lim && irq_cnt[b] == 0; k++) @(negedge clk);
    chk("irq pulses", 8'(irq_cnt[b]), 8'h01);
  endtask

  // immediate byte from a random draw; start and stop are kept for the program scenarios
  function automatic logic [7:0] imm_code(input int r);
    imm_code = {`IMM_TOP_BITS, r[4:0]};
    if (imm_code == `IMM_START || imm_code == `IMM_STOP) imm_code = 8'he5;
  endfunction

  function automatic logic [7:0] wait_op(input int w);
    wait_op = {`WAIT_TOP_BITS, w[4:0]};
  endfunction

  initial begin
    seed = 34;
    rst = 1'h1;
    cpu_req = '0;
    reg_wr_v = 5'h00;
    reg_wdata = 8'h00;
    irq_cnt = '{0, 0, 0};
    repeat (6) @(negedge clk);
    rst = 1'h0;
    chk("port reset", cpu_rdata, `STROBE_PORT_RESET);
    chk("countdown reset", reg_t, `COUNTDOWN_HOLD);
    chk("running reset", running, 1'h0);
    // random immediate strobes, each a single pulse carrying the written byte
    for (int i = 0; i < 12; i++) begin
      code = imm_code($random(seed));
      port_wr(code);
      chk("strobe valid", s1.valid, 1'h1);
      chk("strobe code", s1.code, code);
      chk("strobe gone", s2.valid, 1'h0);
    end
    chk("strobe count", 8'(strobe_cnt), 8'h0c);
    // back-to-back immediates: wr held high, data changed after the first edge
    cpu_req.wr = 1'h1;
    cpu_req.wdata = 8'he3;
    @(negedge clk);
    chk("pair first", strobe.code, 8'he3);
    cpu_req.wdata = 8'he4;
    @(negedge clk);
    cpu_req.wr = 1'h0;
    chk("pair second", {strobe.valid, strobe.code[6:0]}, 8'he4);
    cpu_rd();
    chk("idle read", cpu_rdata, `NOP_OPCODE);
    // data and control registers take random bytes
    for (int i = 0; i < 5; i++) begin
      code = 8'($random(seed));
      reg_wr(i, code);
      chk("data reg", regs_out[i], code);
    end
    reg_wr(0, 8'h00);
    reg_wr(1, `COUNTDOWN_HOLD);
    // untouched memory: start runs all nop slots then stops at the end
    irq_cnt = '{0, 0, 0};
    port_wr(`IMM_START);
    chk("running", running, 1'h1);
    cpu_rd();
    chk("nop read", cpu_rdata, `NOP_OPCODE);
    // immediate cuts into a running fetch, then the program carries on
    port_wr(8'he7);
    chk("run preempt", {s1.valid, s1.code[6:0]}, 8'he7);
    wait_irq(2, 80);
    @(negedge clk);
    chk("stopped", running, 1'h0);
    // loaded program: interrupt, wait two overflows, stop; immediate cut in during the wait
    port_wr(`IMM_STOP);
    port_wr(`PRG_INT);
    port_wr(wait_op(2));
    port_wr(`PRG_STOP);
    irq_cnt = '{0, 0, 0};
    port_wr(`IMM_START);
    wait_irq(0, 10);
    @(negedge clk);
    cpu_rd();
    chk("run read", cpu_rdata, wait_op(2));
    port_wr(8'he6);
    chk("preempt code", {s1.valid, s1.code[6:0]}, 8'he6);
    wait_irq(1, 40);
    wait_irq(2, 10);
    @(negedge clk);
    chk("prog done", running, 1'h0);
    // countdown of three overflows ends a 32-overflow wait early
    port_wr(`IMM_STOP);
    port_wr(wait_op(0));
    reg_wr(1, 8'h03);
    irq_cnt = '{0, 0, 0};
    port_wr(`IMM_START);
    wait_irq(2, 60);
    chk("no wait irq", 8'(irq_cnt[1]), 8'h00);
    chk("countdown end", reg_t, 8'h00);
    @(negedge clk);
    chk("halted", running, 1'h0);
    // x at zero: incy, program strobe, waitx without wait, skip over a second incy, stop
    port_wr(`IMM_STOP);
    reg_wr(1, `COUNTDOWN_HOLD);
    reg_wr(4, 8'h00);
    reg_wr(3, 8'h10);
    port_wr(`PRG_INCY);
    port_wr(8'hc5);
    port_wr(`PRG_WAITX);
    port_wr(8'h10);
    port_wr(`PRG_INCY);
    port_wr(`PRG_STOP);
    irq_cnt = '{0, 0, 0};
    port_wr(`IMM_START);
    wait_irq(2, 20);
    chk("y after skip", reg_y, 8'h11);
    chk("waitx no irq", 8'(irq_cnt[1]), 8'h00);
    chk("program strobe", last_code, 8'hc5);
    test_done();
  end
endmodule
